// >>> rtl/bcb_pkg.sv
// package of constants and types for the carry-bit and branch execution unit
package bcb_pkg;

   // ************************************************************
   // operation codes
   // ************************************************************
   typedef enum logic [3:0] {
      OP_NONE       = 4'h0,
      OP_XOR        = 4'h1,
      OP_INV_XOR    = 4'h2,
      OP_LOAD       = 4'h3,
      OP_INV_LOAD   = 4'h4,
      OP_STORE      = 4'h5,
      OP_INV_STORE  = 4'h6,
      OP_BRANCH     = 4'h7,
      OP_JUMP       = 4'h8,
      OP_CALL_REL   = 4'h9,
      OP_CALL_ABS   = 4'hA,
      OP_RETURN     = 4'hB
   } op_type;

   // ************************************************************
   // condition codes
   // ************************************************************
   typedef enum logic [3:0] {
      CC_ALWAYS    = 4'h0,
      CC_NEVER     = 4'h1,
      CC_HIGHER    = 4'h2,
      CC_LOWER_SAME= 4'h3,
      CC_CARRY_CLR = 4'h4,
      CC_CARRY_SET = 4'h5,
      CC_NOT_EQUAL = 4'h6,
      CC_EQUAL     = 4'h7,
      CC_OVF_CLR   = 4'h8,
      CC_OVF_SET   = 4'h9,
      CC_PLUS      = 4'hA,
      CC_MINUS     = 4'hB,
      CC_SIGNED_GE = 4'hC,
      CC_SIGNED_LT = 4'hD,
      CC_SIGNED_GT = 4'hE,
      CC_SIGNED_LE = 4'hF
   } cond_type;

   localparam int ADDR_W = 24;
   localparam int SP_DEPTH = 8;
   localparam int SP_W = 3;
   localparam logic [ADDR_W-1:0] PC_RESET = 24'h000000;
   localparam logic [ADDR_W-1:0] INSN_LEN = 24'h000002;

   typedef struct packed {
      logic c;
      logic v;
      logic z;
      logic n;
   } flags_type;

   typedef struct packed {
      logic                valid;
      op_type              op;
      cond_type            cond;
      logic                bit_from_reg;
      logic [2:0]          bit_imm;
      logic [2:0]          bit_reg;
      logic [7:0]          operand;
      logic [ADDR_W-1:0]   target;
   } req_type;

   typedef struct packed {
      logic                byte_we;
      logic [7:0]          byte_data;
      logic                taken;
      logic [ADDR_W-1:0]   pc;
      flags_type           flags;
      logic                stack_err;
   } resp_type;

endpackage

// >>> rtl/bit_carry_branch_unit.sv
// execution unit for carry-bit instructions and control transfers
//
// Behaviour
// - xor carry with selected operand bit
// - xor carry with inverted operand bit
// - inverted forms use only immediate bit number
// - load selected bit into carry
// - load inverted selected bit into carry
// - store carry into selected bit only
// - store inverted carry into selected bit
// - branch only when condition true
// - single-flag conditions test C, Z, V, N
// - compound conditions use OR and XOR terms
// - calls save return address then jump
// - return restores saved address
`timescale 1ns/1ps

module bit_carry_branch_unit (
   // ************************************************************
   // clock and reset
   // ************************************************************
   input  wire logic             clk_sys_i,
   input  wire logic             rst_b_i,
   // instruction request and flag load
   input  wire bcb_pkg::req_type req_i,
   input  wire logic             flag_load_i,
   input  wire bcb_pkg::flags_type flag_val_i,
   // result
   output bcb_pkg::resp_type     resp_o
);
   import bcb_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      flags_type                       flags;
      logic [ADDR_W-1:0]               pc;
      logic                            taken;
      logic                            byte_we;
      logic [7:0]                      byte_data;
      logic                            stack_err;
      logic [SP_W:0]                   sp;
      logic [SP_DEPTH-1:0][ADDR_W-1:0] stack;
   } state_type;

   state_type st_ff;
   state_type nxt_st;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic cond_eval(input cond_type cc, input flags_type f);
      logic r;
      r = 1'b0;
      case (cc)
         CC_ALWAYS:     r = 1'b1;
         CC_NEVER:      r = 1'b0;
         CC_HIGHER:     r = ~(f.c | f.z);
         CC_LOWER_SAME: r = f.c | f.z;
         CC_CARRY_CLR:  r = ~f.c;
         CC_CARRY_SET:  r = f.c;
         CC_NOT_EQUAL:  r = ~f.z;
         CC_EQUAL:      r = f.z;
         CC_OVF_CLR:    r = ~f.v;
         CC_OVF_SET:    r = f.v;
         CC_PLUS:       r = ~f.n;
         CC_MINUS:      r = f.n;
         CC_SIGNED_GE:  r = ~(f.n ^ f.v);
         CC_SIGNED_LT:  r = f.n ^ f.v;
         CC_SIGNED_GT:  r = ~(f.z | (f.n ^ f.v));
         CC_SIGNED_LE:  r = f.z | (f.n ^ f.v);
         default:       r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic inv_op(input op_type op);
      return (op == OP_INV_XOR) || (op == OP_INV_LOAD) || (op == OP_INV_STORE);
   endfunction

   logic [2:0] bit_sel;
   logic       sel_bit;

   // inverted forms ignore the register-supplied bit number
   assign bit_sel = (req_i.bit_from_reg && !inv_op(req_i.op)) ? req_i.bit_reg
                                                              : req_i.bit_imm;
   assign sel_bit = req_i.operand[bit_sel];

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      nxt_st           = st_ff;
      nxt_st.taken     = 1'b0;
      nxt_st.byte_we   = 1'b0;
      nxt_st.stack_err = 1'b0;
      if (flag_load_i) begin
         nxt_st.flags = flag_val_i;
      end
      if (req_i.valid) begin
         nxt_st.pc = st_ff.pc + INSN_LEN;
         case (req_i.op)
            OP_XOR:       nxt_st.flags.c = st_ff.flags.c ^ sel_bit;
            OP_INV_XOR:   nxt_st.flags.c = st_ff.flags.c ^ ~sel_bit;
            OP_LOAD:      nxt_st.flags.c = sel_bit;
            OP_INV_LOAD:  nxt_st.flags.c = ~sel_bit;
            OP_STORE: begin
               nxt_st.byte_we            = 1'b1;
               nxt_st.byte_data          = req_i.operand;
               nxt_st.byte_data[bit_sel] = st_ff.flags.c;
            end
            OP_INV_STORE: begin
               nxt_st.byte_we            = 1'b1;
               nxt_st.byte_data          = req_i.operand;
               nxt_st.byte_data[bit_sel] = ~st_ff.flags.c;
            end
            OP_BRANCH: begin
               if (cond_eval(req_i.cond, st_ff.flags)) begin
                  nxt_st.taken = 1'b1;
                  nxt_st.pc    = req_i.target;
               end
            end
            OP_JUMP: begin
               nxt_st.taken = 1'b1;
               nxt_st.pc    = req_i.target;
            end
            OP_CALL_REL, OP_CALL_ABS: begin
               // a full return stack refuses the call rather than overwrite
               if (st_ff.sp == SP_DEPTH[SP_W:0]) begin
                  nxt_st.stack_err = 1'b1;
               end else begin
                  nxt_st.stack[st_ff.sp[SP_W-1:0]] = st_ff.pc + INSN_LEN;
                  nxt_st.sp    = st_ff.sp + 1'b1;
                  nxt_st.taken = 1'b1;
                  nxt_st.pc    = req_i.target;
               end
            end
            OP_RETURN: begin
               if (st_ff.sp == '0) begin
                  nxt_st.stack_err = 1'b1;
               end else begin
                  nxt_st.sp    = st_ff.sp - 1'b1;
                  nxt_st.taken = 1'b1;
                  nxt_st.pc    = st_ff.stack[nxt_st.sp[SP_W-1:0]];
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_ff    <= '0;
         st_ff.pc <= PC_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_comb begin
      resp_o.byte_we   = st_ff.byte_we;
      resp_o.byte_data = st_ff.byte_data;
      resp_o.taken     = st_ff.taken;
      resp_o.pc        = st_ff.pc;
      resp_o.flags     = st_ff.flags;
      resp_o.stack_err = st_ff.stack_err;
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   xor_carry_a: assert property (req_i.valid && req_i.op == OP_XOR && !flag_load_i
      |=> resp_o.flags.c == ($past(resp_o.flags.c) ^ $past(sel_bit)))
      else $error("xor carry wrong");
   inv_xor_a: assert property (req_i.valid && req_i.op == OP_INV_XOR && !flag_load_i
      |=> resp_o.flags.c == ($past(resp_o.flags.c) ^ ~$past(sel_bit)))
      else $error("inverted xor carry wrong");
   inv_bit_a: assert property (req_i.valid && inv_op(req_i.op)
      |-> bit_sel == req_i.bit_imm)
      else $error("inverted form used register bit");
   load_carry_a: assert property (req_i.valid && req_i.op == OP_LOAD && !flag_load_i
      |=> resp_o.flags.c == $past(req_i.operand[bit_sel]))
      else $error("load carry wrong");
   inv_load_a: assert property (req_i.valid && req_i.op == OP_INV_LOAD && !flag_load_i
      |=> resp_o.flags.c != $past(req_i.operand[bit_sel]))
      else $error("inverted load wrong");
   store_bit_a: assert property (req_i.valid && req_i.op == OP_STORE
      |=> resp_o.byte_we && resp_o.byte_data[$past(bit_sel)] == $past(resp_o.flags.c)
          && ((resp_o.byte_data ^ $past(req_i.operand)) & ~(8'h01 << $past(bit_sel)))
             == 8'h00)
      else $error("store bit wrong");
   inv_store_a: assert property (req_i.valid && req_i.op == OP_INV_STORE
      |=> resp_o.byte_we && resp_o.byte_data[$past(bit_sel)] != $past(resp_o.flags.c))
      else $error("inverted store wrong");
   branch_take_a: assert property (req_i.valid && req_i.op == OP_BRANCH
      |=> resp_o.taken == cond_eval($past(req_i.cond), $past(resp_o.flags)))
      else $error("branch decision wrong");
   never_take_a: assert property (req_i.valid && req_i.op == OP_BRANCH
      && req_i.cond == CC_NEVER |=> !resp_o.taken)
      else $error("never branch taken");
   signed_gt_a: assert property (req_i.valid && req_i.op == OP_BRANCH
      && req_i.cond == CC_SIGNED_GT && (resp_o.flags.n ^ resp_o.flags.v)
      |=> !resp_o.taken)
      else $error("signed greater taken wrongly");
   call_ret_a: assert property (req_i.valid && req_i.op == OP_CALL_ABS && !resp_o.stack_err
      && st_ff.sp != SP_DEPTH[SP_W:0] ##1 req_i.valid && req_i.op == OP_RETURN
      |=> resp_o.pc == $past(resp_o.pc, 2) + INSN_LEN)
      else $error("return address wrong");
   jump_flags_a: assert property (req_i.valid && req_i.op == OP_JUMP && !flag_load_i
      |=> resp_o.taken && resp_o.pc == $past(req_i.target)
          && resp_o.flags == $past(resp_o.flags))
      else $error("jump wrong");
   flags_keep_a: assert property (!flag_load_i && !(req_i.valid && req_i.op inside
      {OP_XOR, OP_INV_XOR, OP_LOAD, OP_INV_LOAD})
      |=> resp_o.flags == $past(resp_o.flags))
      else $error("flags changed unexpectedly");

   cov_branch_c: cover property (req_i.valid && req_i.op == OP_BRANCH ##1 resp_o.taken);
   cov_store_c:  cover property (req_i.valid && req_i.op == OP_INV_STORE);
   cov_call_c:   cover property (req_i.valid && req_i.op == OP_CALL_REL
                                 ##[1:4] req_i.valid && req_i.op == OP_RETURN);
   cov_err_c:    cover property (resp_o.stack_err);

endmodule // bit_carry_branch_unit

// >>> bench/bit_carry_branch_unit_test.sv
// self-checking testbench of the carry-bit and branch execution unit
`timescale 1ns/1ps

module bit_carry_branch_unit_test;
   import bcb_pkg::*;

   // ************************************************************
   // signals and reference state
   // ************************************************************
   logic           clk_sys;
   logic           rst_b;
   req_type        req;
   logic           flag_load;
   flags_type      flag_val;
   resp_type       resp;
   resp_type       exp_st;
   resp_type       exp_q[$];
   logic [ADDR_W-1:0] stk[SP_DEPTH];
   int             sp;
   int             err_count;
   int             n_tests;
   int             seed;

   bit_carry_branch_unit DUT (
      .clk_sys_i   (clk_sys),
      .rst_b_i     (rst_b),
      .req_i       (req),
      .flag_load_i (flag_load),
      .flag_val_i  (flag_val),
      .resp_o      (resp)
   );

   always #2.5 clk_sys = ~clk_sys;

   // ************************************************************
   // reference model and driver
   // ************************************************************
   function automatic logic cond_true(input cond_type cc, input flags_type f);
      case (cc)
         CC_ALWAYS:     return 1'b1;
         CC_NEVER:      return 1'b0;
         CC_HIGHER:     return !(f.c | f.z);
         CC_LOWER_SAME: return f.c | f.z;
         CC_CARRY_CLR:  return !f.c;
         CC_CARRY_SET:  return f.c;
         CC_NOT_EQUAL:  return !f.z;
         CC_EQUAL:      return f.z;
         CC_OVF_CLR:    return !f.v;
         CC_OVF_SET:    return f.v;
         CC_PLUS:       return !f.n;
         CC_MINUS:      return f.n;
         CC_SIGNED_GE:  return !(f.n ^ f.v);
         CC_SIGNED_LT:  return f.n ^ f.v;
         CC_SIGNED_GT:  return !(f.z | (f.n ^ f.v));
         default:       return f.z | (f.n ^ f.v);
      endcase
   endfunction

   // drive one cycle at the falling edge and note what must follow it
   task automatic issue(input req_type r, input logic fl, input flags_type fv);
      resp_type    e;
      logic [2:0]  s;
      logic        b;
      @(negedge clk_sys);
      req = r;
      flag_load = fl;
      flag_val = fv;
      e = exp_st;
      e.byte_we = 1'b0;
      e.taken = 1'b0;
      e.stack_err = 1'b0;
      if (fl) e.flags = fv;
      if (r.valid) begin
         s = (r.bit_from_reg && r.op inside {OP_XOR, OP_LOAD, OP_STORE}) ? r.bit_reg : r.bit_imm;
         b = r.operand[s];
         e.pc = exp_st.pc + INSN_LEN;
         case (r.op)
            OP_XOR:      e.flags.c = exp_st.flags.c ^ b;
            OP_INV_XOR:  e.flags.c = exp_st.flags.c ^ ~b;
            OP_LOAD:     e.flags.c = b;
            OP_INV_LOAD: e.flags.c = ~b;
            OP_STORE, OP_INV_STORE: begin
               e.byte_we = 1'b1;
               e.byte_data = r.operand;
               e.byte_data[s] = exp_st.flags.c ^ (r.op == OP_INV_STORE);
            end
            OP_BRANCH: if (cond_true(r.cond, exp_st.flags)) begin
               e.taken = 1'b1;
               e.pc = r.target;
            end
            OP_JUMP: begin
               e.pc = r.target;
               e.taken = 1'b1;
            end
            OP_CALL_REL, OP_CALL_ABS: if (sp == SP_DEPTH) e.stack_err = 1'b1;
            else begin
               stk[sp] = e.pc;
               sp++;
               e.taken = 1'b1;
               e.pc = r.target;
            end
            OP_RETURN: if (sp == 0) e.stack_err = 1'b1;
            else begin
               sp--;
               e.pc = stk[sp];
               e.taken = 1'b1;
            end
            default: ;
         endcase
      end
      exp_st = e;
      exp_q.push_back(e);
   endtask

   function automatic req_type mk(input op_type op, input cond_type cc);
      req_type r;
      r.valid = 1'b1;
      r.op = op;
      r.cond = cc;
      r.bit_from_reg = 1'($random(seed));
      r.bit_imm = 3'($random(seed));
      r.bit_reg = 3'($random(seed));
      r.operand = 8'($random(seed));
      r.target = ADDR_W'($random(seed));
      return r;
   endfunction

   // ************************************************************
   // monitor and report
   // ************************************************************
   task automatic cmp_resp(input resp_type e, input resp_type g);
      n_tests++;
      if (g !== e) begin
         $display("unexpected resp_o expected %h seen %h", e, g);
         err_count++;
      end
   endtask

   always @(posedge clk_sys) begin
      resp_type e;
      #1;
      if (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         cmp_resp(e, resp);
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // idle the request so the last instruction is not executed again unnoted
   task automatic drain();
      @(negedge clk_sys);
      req = '0;
      flag_load = 1'b0;
      for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(posedge clk_sys);
      if (exp_q.size() > 0) err_count++;
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      req_type r;
      op_type  op;
      logic    fl;
      seed = 32'hd68499ed;
      clk_sys = 1'b0;
      rst_b = 1'b0;
      req = '0;
      flag_load = 1'b0;
      flag_val = '0;
      exp_st = '0;
      sp = 0;
      err_count = 0;
      n_tests = 0;
      repeat (2) @(negedge clk_sys);
      rst_b = 1'b1;
      issue('0, 1'b0, '0);
      for (int cc = 0; cc < 16; cc++) begin
         for (int f = 0; f < 16; f++) begin
            issue('0, 1'b1, flags_type'(f));
            issue(mk(OP_BRANCH, cond_type'(cc)), 1'b0, '0);
         end
      end
      // carry loads may share a cycle with a flag load: the load of C wins
      repeat (300) begin
         op = op_type'(4'h1 + 4'($unsigned($random(seed)) % 6));
         fl = (op inside {OP_LOAD, OP_INV_LOAD}) && 1'($random(seed));
         issue(mk(op, CC_ALWAYS), fl, flags_type'(4'($random(seed))));
      end
      issue(mk(OP_JUMP, CC_NEVER), 1'b0, '0);
      repeat (SP_DEPTH + 1) issue(mk(OP_CALL_ABS, CC_ALWAYS), 1'b0, '0);
      repeat (SP_DEPTH + 1) issue(mk(OP_RETURN, CC_ALWAYS), 1'b0, '0);
      issue(mk(OP_CALL_REL, CC_ALWAYS), 1'b0, '0);
      issue(mk(OP_RETURN, CC_ALWAYS), 1'b0, '0);
      repeat (400) begin
         r = mk(op_type'(4'($random(seed))), cond_type'(4'($random(seed))));
         r.valid = 1'($random(seed));
         fl = !(r.op inside {OP_XOR, OP_INV_XOR}) && 1'($random(seed));
         issue(r, fl, flags_type'(4'($random(seed))));
      end
      drain();
      @(negedge clk_sys);
      rst_b = 1'b0;
      @(negedge clk_sys);
      rst_b = 1'b1;
      exp_st = '0;
      sp = 0;
      issue('0, 1'b0, '0);
      issue(mk(OP_RETURN, CC_ALWAYS), 1'b0, '0);
      issue(mk(OP_STORE, CC_ALWAYS), 1'b0, '0);
      drain();
      end_of_test();
   end

endmodule // bit_carry_branch_unit_test
